// File: core_sequencer_model.sv
`timescale 1ns/1ns
`include "return_stack_defines.svh"

// =====================================================
// core sequencer stand-in: one call or return per command cycle
module core_sequencer_model
    import return_stack_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic call_cmd,
    input wire logic ret_cmd,
    input wire pc_t call_pc,
    input wire pc_t return_pc,
    output logic push_request,
    output logic pop_request,
    output pc_t push_pc,
    output pc_t popped_pc
);
    // requests registered so they change just after an edge
    // call pushes, return pops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            push_request <= 1'b0;
            pop_request <= 1'b0;
            push_pc <= '0;
            popped_pc <= '0;
        end else begin
            push_request <= call_cmd;
            pop_request <= ret_cmd & ~call_cmd;
            // idle address shows a toggling value, not the last one
            push_pc <= call_cmd ? call_pc : ~push_pc;
            // the core takes the top entry in the pop cycle itself
            if (pop_request) begin
                popped_pc <= return_pc;
            end
        end
    end
endmodule // core_sequencer_model

// File: hardware_return_stack.sv
`timescale 1ns/1ns
`include "return_stack_defines.svh"

// =====================================================
// return address stack with ahb-lite register access
module hardware_return_stack
    import return_stack_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic push_request,
    input wire pc_t push_pc,
    input wire logic pop_request,
    output pc_t return_pc,
    output logic stack_fault_reset_request,
    output logic stack_overflow_flag,
    output logic stack_underflow_flag
);

    // =====================================================
    // state
    ptr_t return_stack_pointer;
    logic stack_fault_reset_enable;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    pc_t top_raw;

    // =====================================================
    // ahb address phase capture
    wire addr_take = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];

    // hsize is ignored: only whole-word transfers are in use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready) begin
            dp_valid <= addr_take;
            dp_write <= hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = `HRESP_OKAY;

    // =====================================================
    // data phase decode
    wire wr_phase = dp_valid && dp_write;
    wire rd_phase = dp_valid && !dp_write;
    wire hit_pointer = (dp_addr == `OFF_POINTER);
    wire hit_low = (dp_addr == `OFF_TOP_LOW);
    wire hit_high = (dp_addr == `OFF_TOP_HIGH);
    wire hit_control = (dp_addr == `OFF_CONTROL);
    wire ctrl_wr = wr_phase && hit_control;

    // =====================================================
    // core requests: a push wins if the core ever asks for both
    // [RULE3] push on call
    wire push_act = push_request;
    // [RULE4] pop on return
    wire pop_act = pop_request && !push_request;
    wire core_busy = push_act || pop_act;
    // bus writes to stack state yield to core activity in the same cycle
    wire ptr_wr = wr_phase && hit_pointer && !core_busy;
    wire low_wr = wr_phase && hit_low && !core_busy;
    wire high_wr = wr_phase && hit_high && !core_busy;

    // =====================================================
    // fault detection
    wire is_empty = (return_stack_pointer == `PTR_RESET);
    // [RULE9] five-bit pointer shows full and empty
    wire overflow_event = push_act && (return_stack_pointer == `PTR_FULL);
    wire underflow_event = pop_act && is_empty;

    // =====================================================
    // next pointer
    ptr_t next_ptr;
    // [RULE10] increment before the write
    wire ptr_t ptr_inc = return_stack_pointer + `PTR_STEP;
    // [RULE11] decrement after the entry is returned
    wire ptr_t ptr_dec = return_stack_pointer - `PTR_STEP;
    // [RULE8] software positions the pointer
    wire ptr_t ptr_sw = hwdata[`PTR_WIDTH-1:0];

    // [RULE6] low four bits wrap so push seventeen lands on entry zero
    assign next_ptr = push_act ? ptr_inc :
                      pop_act ? ptr_dec :
                      ptr_wr ? ptr_sw :
                      return_stack_pointer;

    // [RULE12] empty pointer after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            return_stack_pointer <= `PTR_RESET;
        end else begin
            return_stack_pointer <= next_ptr;
        end
    end

    // =====================================================
    // entry selection
    // [RULE14] empty pointer looks at the alias entry
    wire index_t next_index = (next_ptr == `PTR_RESET) ? `EMPTY_ALIAS : next_ptr[`INDEX_WIDTH-1:0];
    wire index_t cur_index = is_empty ? `EMPTY_ALIAS : return_stack_pointer[`INDEX_WIDTH-1:0];

    // =====================================================
    // storage write port
    // [RULE16] low byte and high seven bits are patched separately
    wire pc_t low_merge = {top_raw[`PC_WIDTH-1:8], hwdata[7:0]};
    wire pc_t high_merge = {hwdata[`PC_WIDTH-9:0], top_raw[7:0]};
    wire mem_we = push_act || low_wr || high_wr;
    wire index_t mem_waddr = push_act ? next_ptr[`INDEX_WIDTH-1:0] : cur_index;
    wire pc_t mem_wdata = push_act ? push_pc : (low_wr ? low_merge : high_merge);

    // [RULE1] sixteen by fifteen entries
    // [RULE2] private array, not mapped into any memory space
    stack_memory storage (
        .hclk(hclk),
        .hresetn(hresetn),
        .write_enable(mem_we),
        .write_index(mem_waddr),
        .write_data(mem_wdata),
        .read_index(next_index),
        .read_data(top_raw)
    );

    // =====================================================
    // top entry view
    // [RULE13] empty with fault reset on reads zero
    wire pc_t top_entry = (is_empty && stack_fault_reset_enable) ? '0 : top_raw;
    wire [7:0] top_entry_low = top_entry[7:0];
    wire [6:0] top_entry_high = top_entry[`PC_WIDTH-1:8];

    // [RULE11] returned address is the pointed entry before decrement
    assign return_pc = top_entry;

    // [RULE5] no port to the high latch, so push and pop cannot alter it

    // =====================================================
    // flags: hardware set wins over a software clear
    wire clr_ovf = ctrl_wr && !hwdata[`BIT_OVERFLOW];
    wire clr_unf = ctrl_wr && !hwdata[`BIT_UNDERFLOW];
    // [RULE7] flags set in both fault modes
    wire next_overflow = overflow_event || (stack_overflow_flag && !clr_ovf);
    wire next_underflow = underflow_event || (stack_underflow_flag && !clr_unf);
    // [RULE15] fault requests a device reset when enabled
    wire fault_req_set = stack_fault_reset_enable && (overflow_event || underflow_event);

    // flags are written back as zero to clear, ones leave them alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stack_overflow_flag <= 1'b0;
            stack_underflow_flag <= 1'b0;
        end else begin
            stack_overflow_flag <= next_overflow;
            stack_underflow_flag <= next_underflow;
        end
    end

    // request holds until the device reset that it asks for
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stack_fault_reset_request <= 1'b0;
        end else if (fault_req_set) begin
            stack_fault_reset_request <= 1'b1;
        end
    end

    // fault reset enable stands in for the configuration bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stack_fault_reset_enable <= `FAULT_EN_RESET;
        end else if (ctrl_wr) begin
            stack_fault_reset_enable <= hwdata[`BIT_FAULT_EN];
        end
    end

    // =====================================================
    // read data mux, valid during the data phase
    wire [31:0] rd_pointer = {27'h000_0000, return_stack_pointer};
    wire [31:0] rd_low = {24'h00_0000, top_entry_low};
    wire [31:0] rd_high = {25'h000_0000, top_entry_high};
    wire [31:0] rd_control = {29'h0000_0000, stack_underflow_flag, stack_overflow_flag,
                              stack_fault_reset_enable};

    // [RULE8] pointer and top entry pair read back
    // a read that follows a write sees the written value: the mux looks at live flops
    assign hrdata = !rd_phase ? 32'h0000_0000 :
                    hit_pointer ? rd_pointer :
                    hit_low ? rd_low :
                    hit_high ? rd_high :
                    hit_control ? rd_control :
                    32'h0000_0000;

    // =====================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // push then pop returns to the starting depth
    sequence push_step;
        push_request && !pop_request;
    endsequence

    sequence pop_step;
        pop_request && !push_request;
    endsequence

    sequence push_then_pop;
        push_step ##1 pop_step;
    endsequence

    a_push_increments: assert property ( // [RULE10]
        push_step |=> return_stack_pointer == $past(return_stack_pointer) + 5'h01)
        else $error("pointer did not step up on push");

    a_push_stores_pc: assert property ( // [RULE3]
        push_step |=> top_raw == $past(push_pc))
        else $error("pushed address not at top");

    a_pop_decrements: assert property ( // [RULE11]
        pop_step |=> return_stack_pointer == $past(return_stack_pointer) - 5'h01)
        else $error("pointer did not step down on pop");

    a_call_return_pair: assert property ( // [RULE4]
        push_then_pop |=> return_stack_pointer == $past(return_stack_pointer, 2))
        else $error("push then pop lost depth");

    a_overflow_flag: assert property ( // [RULE7]
        (push_step and return_stack_pointer == 5'h0F) |=> stack_overflow_flag)
        else $error("overflow flag missing");

    // a zero written in the cycle after the set may drop the flag one cycle later
    a_underflow_flag: assert property ( // [RULE7]
        (pop_step and return_stack_pointer == 5'h1F) |=> stack_underflow_flag ##1 (stack_underflow_flag || $past(clr_unf)))
        else $error("underflow flag missing");

    a_fault_reset: assert property ( // [RULE15]
        (push_step and return_stack_pointer == 5'h0F and stack_fault_reset_enable)
        |=> stack_fault_reset_request [*2])
        else $error("fault reset not requested");

    a_no_fault_req: assert property ( // [RULE15]
        !stack_fault_reset_enable && !stack_fault_reset_request |=> !stack_fault_reset_request)
        else $error("fault reset raised while disabled");

    a_wrap_index: assert property ( // [RULE6]
        (push_step and return_stack_pointer == 5'h0F and !stack_fault_reset_enable)
        |=> return_stack_pointer[3:0] == 4'h0)
        else $error("wrap did not reach entry zero");

    a_empty_zero: assert property ( // [RULE13]
        is_empty && stack_fault_reset_enable |-> top_entry == 15'h0000)
        else $error("empty stack read not zero");

    a_empty_alias: assert property ( // [RULE14]
        ##1 (is_empty && !stack_fault_reset_enable && $stable(return_stack_pointer)
        && !$past(mem_we)) |-> top_entry == $past(top_raw))
        else $error("empty stack alias read unstable");

    a_reset_pointer: assert property ( // [RULE12]
        $rose(dp_valid) && $past(return_stack_pointer) == 5'h1F && !$past(core_busy)
        && !$past(ptr_wr) |-> return_stack_pointer == 5'h1F)
        else $error("empty pointer drifted");

    a_return_pc: assert property ( // [RULE11]
        (pop_step and !is_empty) |-> return_pc == top_raw)
        else $error("returned address is not the pointed entry");

    // software access steps, one data phase each
    sequence sw_pointer_write;
        wr_phase && hit_pointer && !core_busy;
    endsequence

    sequence sw_top_read;
        rd_phase && (hit_low || hit_high);
    endsequence

    // reset values: the default disable would hide them, so it is switched off here
    a_reset_empty: assert property ( // [RULE12]
        @(posedge hclk) disable iff (1'b0) (!hresetn ##1 hresetn) |-> return_stack_pointer == 5'h1F
        && stack_fault_reset_enable && !stack_overflow_flag && !stack_underflow_flag)
        else $error("state after reset is not empty");

    a_pointer_write: assert property ( // [RULE8]
        sw_pointer_write |=> return_stack_pointer == $past(hwdata[4:0]))
        else $error("pointer write did not land");

    // write-through makes a patched byte visible at the very next edge
    a_low_write: assert property ( // [RULE16]
        low_wr |=> top_raw[7:0] == $past(hwdata[7:0]))
        else $error("low byte write did not land");

    a_high_write: assert property ( // [RULE16]
        high_wr |=> top_raw[14:8] == $past(hwdata[6:0]))
        else $error("high bits write did not land");

    a_empty_read: assert property ( // [RULE13]
        (sw_top_read and is_empty && stack_fault_reset_enable) |-> hrdata == 32'h0000_0000)
        else $error("empty stack bus read not zero");

    // flags stay up until software writes a zero over them
    a_ovf_sticky: assert property ( // [RULE7]
        stack_overflow_flag && !clr_ovf |=> stack_overflow_flag)
        else $error("overflow flag dropped");

    a_unf_sticky: assert property ( // [RULE7]
        stack_underflow_flag && !clr_unf |=> stack_underflow_flag)
        else $error("underflow flag dropped");

    a_ovf_clear: assert property ( // [RULE7]
        clr_ovf && !overflow_event |=> !stack_overflow_flag)
        else $error("overflow flag not cleared");

    a_unf_clear: assert property ( // [RULE7]
        clr_unf && !underflow_event |=> !stack_underflow_flag)
        else $error("underflow flag not cleared");

    // a fault request may only end with the reset that it asks for
    a_request_sticky: assert property ( // [RULE15]
        stack_fault_reset_request |=> stack_fault_reset_request)
        else $error("fault reset request dropped");

    a_underflow_request: assert property ( // [RULE15]
        (pop_step and is_empty && stack_fault_reset_enable) |=> stack_fault_reset_request)
        else $error("underflow did not request reset");

endmodule // hardware_return_stack

// File: return_stack_defines.svh
// Notes on behaviour
// [RULE1] The stack holds sixteen entries of fifteen bits, one program counter each.
// [RULE2] Stack storage sits apart from program and data memory spaces.
// [RULE3] Calls, calls via working register and interrupt vectoring push the program counter.
// [RULE4] Plain return, return with literal and return from interrupt pop the stack.
// [RULE5] Push and pop never touch the program counter high latch.
// [RULE6] With fault reset off the stack wraps: push seventeen overwrites push one.
// [RULE7] Overflow and underflow set their flags whether fault reset is on or off.
// [RULE8] Software moves the pointer, then reads or writes the top entry pair.
// [RULE9] The pointer is five bits, one extra bit for overflow and underflow.
// [RULE10] Push increments the pointer first, then writes the program counter there.
// [RULE11] Return takes the pointed entry first, then decrements the pointer.
// [RULE12] After reset the stack is empty with the pointer at 0x1F.
// [RULE13] Empty stack with fault reset on reads the top entry as zero.
// [RULE14] Empty stack with fault reset off reads the top entry from entry 0x0E.
// [RULE15] With fault reset on, overflow or underflow also requests a device reset.
// [RULE16] High register holds entry bits fourteen to eight, low register bits seven to zero.
`ifndef RETURN_STACK_DEFINES_SVH
`define RETURN_STACK_DEFINES_SVH

// =====================================================
// geometry
`define STACK_DEPTH 16
`define PC_WIDTH 15
`define PTR_WIDTH 5
`define INDEX_WIDTH 4

// =====================================================
// pointer values
`define PTR_RESET 5'h1F
`define PTR_FULL 5'h0F
`define PTR_STEP 5'h01
`define EMPTY_ALIAS 4'hE

// =====================================================
// register byte offsets
`define OFF_POINTER 8'h00
`define OFF_TOP_LOW 8'h04
`define OFF_TOP_HIGH 8'h08
`define OFF_CONTROL 8'h0C

// =====================================================
// control register fields
`define BIT_FAULT_EN 0
`define BIT_OVERFLOW 1
`define BIT_UNDERFLOW 2
`define FAULT_EN_RESET 1'b1

// =====================================================
// ahb encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

// File: return_stack_pkg.sv
`include "return_stack_defines.svh"

package return_stack_pkg;
    typedef logic [`PC_WIDTH-1:0] pc_t;
    typedef logic [`PTR_WIDTH-1:0] ptr_t;
    typedef logic [`INDEX_WIDTH-1:0] index_t;
endpackage

// File: stack_memory.sv
`timescale 1ns/1ns
`include "return_stack_defines.svh"

// =====================================================
// stack storage with registered read port
module stack_memory
    import return_stack_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic write_enable,
    input wire index_t write_index,
    input wire pc_t write_data,
    input wire index_t read_index,
    output pc_t read_data
);
    pc_t entries [0:`STACK_DEPTH-1];

    // array has no reset: contents are undefined until pushed or written over the bus
    always_ff @(posedge hclk) begin
        if (write_enable) begin
            entries[write_index] <= write_data;
        end
    end

    // write-through keeps the read port in step with a same-cycle write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            read_data <= '0;
        end else if (write_enable && (write_index == read_index)) begin
            read_data <= write_data;
        end else begin
            read_data <= entries[read_index];
        end
    end
endmodule // stack_memory

// File: tb.sv
`timescale 1ns/1ns
`include "return_stack_defines.svh"

module tb
    import return_stack_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, call_cmd = 0, ret_cmd = 0;
    logic [31:0] haddr = '0, hwdata = '0, rd_q;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic rdy_q, hreadyout, hresp, push_request, pop_request, fault_req, ovf, unf;
    logic [31:0] hrdata;
    pc_t call_pc = '0, push_pc, return_pc, popped_pc;
    pc_t pcs [17];
    int fails = 0, n_checks = 0;

    // =====================================================
    // clock, edge samplers, instances
    initial forever #25 hclk = ~hclk;
    // bus answers taken as they stood at the rising edge
    always @(posedge hclk) begin
        rdy_q <= hreadyout;
        rd_q <= hrdata;
    end
    hardware_return_stack hardware_return_stack_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .push_request(push_request), .push_pc(push_pc), .pop_request(pop_request),
        .return_pc(return_pc), .stack_fault_reset_request(fault_req),
        .stack_overflow_flag(ovf), .stack_underflow_flag(unf));
    core_sequencer_model core_sequencer_model_inst (.hclk(hclk), .hresetn(hresetn), .call_cmd(call_cmd),
        .ret_cmd(ret_cmd), .call_pc(call_pc), .return_pc(return_pc), .push_request(push_request),
        .pop_request(pop_request), .push_pc(push_pc), .popped_pc(popped_pc));

    // =====================================================
    // expectations and checking
    function automatic logic [31:0] low_of(pc_t p);
        return {24'h0000_00, p[7:0]};
    endfunction
    function automatic logic [31:0] high_of(pc_t p);
        return {25'h000_0000, p[14:8]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        if (fails == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // =====================================================
    // bus master: hold each phase until hready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0000_00, a};
        hwrite <= w;
        do begin @(posedge hclk); #1; n++; end while (rdy_q !== 1'b1 && n < 100);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge hclk); #1; n++; end while (rdy_q !== 1'b1 && n < 100);
        r = rd_q;
        chk("hready", 32'h0000_0001, {31'h0, rdy_q});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk(nm, e, r);
    endtask
    task automatic top_chk(input pc_t p);
        rdchk("top_low", `OFF_TOP_LOW, low_of(p));
        rdchk("top_high", `OFF_TOP_HIGH, high_of(p));
    endtask

    // =====================================================
    // core side: back to back calls, single returns
    task automatic calls(input int cnt);
        for (int i = 0; i < cnt; i++) begin
            pcs[i] = pc_t'($urandom);
            call_cmd <= 1'b1;
            call_pc <= pcs[i];
            @(posedge hclk); #1;
        end
        call_cmd <= 1'b0;
        repeat (3) @(posedge hclk);
        #1;
    endtask
    task automatic ret();
        ret_cmd <= 1'b1;
        @(posedge hclk); #1;
        ret_cmd <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
    endtask
    task automatic call_ret(input pc_t p);
        call_cmd <= 1'b1;
        call_pc <= p;
        @(posedge hclk); #1;
        call_cmd <= 1'b0;
        ret_cmd <= 1'b1;
        @(posedge hclk); #1;
        ret_cmd <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
    endtask
    task automatic reset();
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk); #1;
    endtask

    // watchdog well beyond the few hundred cycles of the run
    initial begin
        #(20000 * 50);
        fails++;
        results();
    end

    // =====================================================
    // scenarios
    initial begin
        void'($urandom(32'h57c2a379));
        reset();
        rdchk("pointer", `OFF_POINTER, 32'h0000_001f);
        rdchk("control", `OFF_CONTROL, 32'h0000_0001);
        top_chk('0);
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
        wr(8'h10, 32'hffff_ffff);
        rdchk("unmapped", 8'h10, 32'h0000_0000);
        // fill exactly to depth: no overflow yet
        calls(16);
        chk("return_pc", {17'h0, pcs[15]}, {17'h0, return_pc});
        rdchk("pointer", `OFF_POINTER, 32'h0000_000f);
        rdchk("control", `OFF_CONTROL, 32'h0000_0001);
        chk("ovf", 32'h0000_0000, {31'h0, ovf});
        for (int i = 15; i >= 0; i--) begin
            ret();
            chk("popped", {17'h0, pcs[i]}, {17'h0, popped_pc});
        end
        rdchk("pointer", `OFF_POINTER, 32'h0000_001f);
        // one pop too many with fault reset on
        ret();
        rdchk("control", `OFF_CONTROL, 32'h0000_0005);
        chk("unf", 32'h0000_0001, {31'h0, unf});
        chk("fault_req", 32'h0000_0001, {31'h0, fault_req});
        rdchk("pointer", `OFF_POINTER, 32'h0000_001e);
        // one push too many with fault reset on
        reset();
        calls(17);
        rdchk("control", `OFF_CONTROL, 32'h0000_0003);
        chk("ovf", 32'h0000_0001, {31'h0, ovf});
        chk("fault_req", 32'h0000_0001, {31'h0, fault_req});
        // circular mode: seventeenth push lands on entry zero
        reset();
        wr(`OFF_CONTROL, 32'h0000_0000);
        calls(17);
        rdchk("pointer", `OFF_POINTER, 32'h0000_0010);
        rdchk("control", `OFF_CONTROL, 32'h0000_0002);
        chk("unf", 32'h0000_0000, {31'h0, unf});
        chk("fault_req", 32'h0000_0000, {31'h0, fault_req});
        wr(`OFF_POINTER, 32'h0000_0000);
        top_chk(pcs[16]);
        wr(`OFF_POINTER, 32'h0000_0001);
        top_chk(pcs[1]);
        wr(`OFF_POINTER, 32'h0000_001f);
        top_chk(pcs[14]);
        // software rewrites an entry, the core then returns through it
        wr(`OFF_POINTER, 32'h0000_0005);
        wr(`OFF_TOP_LOW, 32'h0000_00ab);
        wr(`OFF_TOP_HIGH, 32'h0000_0055);
        top_chk(15'h55ab);
        chk("return_pc", 32'h0000_55ab, {17'h0, return_pc});
        ret();
        chk("popped", 32'h0000_55ab, {17'h0, popped_pc});
        rdchk("pointer", `OFF_POINTER, 32'h0000_0004);
        // a call answered at once by a return hands back what it pushed
        pcs[0] = pc_t'($urandom);
        call_ret(pcs[0]);
        chk("popped", {17'h0, pcs[0]}, {17'h0, popped_pc});
        rdchk("pointer", `OFF_POINTER, 32'h0000_0004);
        wr(`OFF_CONTROL, 32'h0000_0000);
        rdchk("control", `OFF_CONTROL, 32'h0000_0000);
        chk("ovf", 32'h0000_0000, {31'h0, ovf});
        results();
    end
endmodule // tb
